// ==== bench/msp_remote_model.sv ====
// Remote asynchronous serial device facing the port's line pins.
// Assumes the bench passes bit length in aclk cycles.
`timescale 1ns/1ps
`default_nettype none
module msp_remote_model (
   // Clock
   input wire logic aclk,
   // Line pins
   input wire logic line_in,
   output logic line_out
);
   initial line_out = 1'b1;
   // Capture one character, sampling each bit near its centre
   task automatic recv(input int nb, input int bc, output logic [8:0] d,
                       output logic stp);
      int i;
      d = '0;
      i = 0;
      while (line_in !== 1'b0 && i < 20000) begin
         @(posedge aclk);
         i++;
      end
      repeat (bc / 2) @(posedge aclk);
      for (i = 0; i < nb; i++) begin
         repeat (bc) @(posedge aclk);
         d[i] = line_in;
      end
      repeat (bc) @(posedge aclk);
      stp = line_in;
   endtask
   // Send one 8-bit character, idle high around it
   task automatic send(input logic [7:0] b, input int bc);
      int i;
      line_out <= 1'b0;
      repeat (bc) @(posedge aclk);
      for (i = 0; i < 8; i++) begin
         line_out <= b[i];
         repeat (bc) @(posedge aclk);
      end
      line_out <= 1'b1;
      repeat (bc) @(posedge aclk);
   endtask
endmodule
`default_nettype wire

// ==== bench/msp_serial_port_tb.sv ====
// Self-checking bench: register tasks over AXI4-Lite plus a line model.
// Assumes byte address is four times the register index.
`timescale 1ns/1ps
`default_nettype none
module msp_serial_port_tb;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, ser_out, ser_in;
   logic [4:0] awaddr, araddr;
   logic [31:0] wdata, rdata, v;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, r;
   logic [8:0] cap;
   logic stp;
   logic aso, bco, oen, bval;
   logic [7:0] bdat;
   int err_total, compares;
   int boots = 0;
   msp_serial_port dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
      .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
      .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
      .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .ser_out(ser_out), .ser_in(ser_in), .alt_ser_out(aso),
      .alt_ser_in(1'b1), .bit_clock_in(1'b1), .bit_clock_out(bco),
      .bit_clock_oe_n(oen), .ext_tx_clock(1'b1), .ext_rx_clock(1'b1),
      .boot_rx_valid(bval), .boot_rx_data(bdat));
   msp_remote_model m (.aclk(aclk), .line_in(ser_out), .line_out(ser_in));
   // Count received-byte pulses for the boot loader
   always @(posedge aclk) begin
      if (bval)
         boots <= boots + 1;
   end
   // Free-running 100 MHz clock
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   task automatic report_and_stop();
      if (err_total == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      compares++;
      if (g !== e) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One register access; w selects write, answer left in r and v
   task automatic bus(input logic w, input logic [2:0] ix,
                      input logic [7:0] d);
      int n;
      logic ta, tw, tb;
      @(posedge aclk);
      awaddr <= {ix, 2'b00};
      araddr <= {ix, 2'b00};
      wdata <= {24'h000000, d};
      awvalid <= w;
      wvalid <= w;
      bready <= w;
      arvalid <= !w;
      rready <= !w;
      for (n = 0; n < 60; n++) begin
         #1;
         ta = (awvalid && awready) || (arvalid && arready);
         tw = wvalid && wready;
         tb = (bvalid && bready) || (rvalid && rready);
         r = w ? bresp : rresp;
         v = rdata;
         @(posedge aclk);
         if (ta) begin
            awvalid <= 1'b0;
            arvalid <= 1'b0;
         end
         if (tw)
            wvalid <= 1'b0;
         if (tb)
            break;
      end
      bready <= 1'b0;
      rready <= 1'b0;
      if (n == 60) begin
         err_total++;
         report_and_stop();
      end
   endtask
   // Main sequence
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata} = '0;
      wstrb = 4'hF;
      err_total = 0;
      compares = 0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      bus(1'b0, msp_pkg::IDX_CTRL, 8'h00);
      chk("ctrl", {24'h000000, msp_pkg::CTRL_RESET}, v);
      bus(1'b0, 3'h6, 8'h00);
      chk("unmapped", {30'h0, msp_pkg::RESP_SLVERR}, {30'h0, r});
      fork
         m.recv(8, 16, cap, stp);
         bus(1'b1, msp_pkg::IDX_DATA, 8'hA5);
      join
      chk("bresp", {30'h0, msp_pkg::RESP_OKAY}, {30'h0, r});
      chk("tx8", 32'h0A5, {23'h0, cap});
      chk("stop", 32'h1, {31'h0, stp});
      bus(1'b1, msp_pkg::IDX_CTRL, 8'h86);
      fork
         m.recv(8, 8, cap, stp);
         bus(1'b1, msp_pkg::IDX_LSTOP, 8'h3C);
      join
      chk("tx7 hi", 32'h0BC, {23'h0, cap});
      fork
         m.recv(8, 8, cap, stp);
         bus(1'b1, msp_pkg::IDX_ADDR, 8'h41);
      join
      chk("tx7 lo", 32'h041, {23'h0, cap});
      bus(1'b1, msp_pkg::IDX_CTRL, 8'h80);
      bus(1'b1, msp_pkg::IDX_EXT, 8'h03);
      bus(1'b0, msp_pkg::IDX_EXT, 8'h00);
      chk("div", 32'h3, v);
      fork
         m.recv(8, 64, cap, stp);
         bus(1'b1, msp_pkg::IDX_DATA, 8'hC3);
      join
      chk("tx div", 32'h0C3, {23'h0, cap});
      m.send(8'h5A, 64);
      bus(1'b0, msp_pkg::IDX_STATUS, 8'h00);
      chk("rx full", 32'h1, {31'h0, v[7]});
      bus(1'b0, msp_pkg::IDX_DATA, 8'h00);
      chk("rx byte", 32'h05A, v);
      chk("boot count", 32'h1, boots);
      chk("boot byte", 32'h05A, {24'h0, bdat});
      chk("alt idle", 32'h1, {31'h0, aso});
      chk("clk idle", 32'h3, {30'h0, bco, oen});
      bus(1'b1, msp_pkg::IDX_CTRL, 8'h90);
      chk("clk drive", 32'h0, {31'h0, oen});
      bus(1'b1, msp_pkg::IDX_CTRL, 8'hA0);
      chk("clk input", 32'h1, {31'h0, oen});
      report_and_stop();
   end
endmodule
`default_nettype wire

// ==== pkg/msp_pkg.sv ====
// Shared constants and types for the multi-mode serial port.
// Assumes a single 100 MHz clock domain and an AXI4-Lite register bus.
package msp_pkg;
   // Register indices; byte address is four times the index
   localparam logic [2:0] IDX_DATA = 3'h0;
   localparam logic [2:0] IDX_ADDR = 3'h1;
   localparam logic [2:0] IDX_LSTOP = 3'h2;
   localparam logic [2:0] IDX_STATUS = 3'h3;
   localparam logic [2:0] IDX_CTRL = 3'h4;
   localparam logic [2:0] IDX_EXT = 3'h5;
   // Reset values
   localparam logic [7:0] CTRL_RESET = 8'h80;
   localparam logic [7:0] EXT_RESET = 8'h00;
   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Oversampling ratios and character lengths
   localparam logic [4:0] OS_X8 = 5'h08;
   localparam logic [4:0] OS_X16 = 5'h10;
   localparam logic [3:0] LEN_SEVEN = 4'h7;
   localparam logic [3:0] LEN_EIGHT = 4'h8;
   localparam logic [3:0] RX_SH_W = 4'h9;
   // Bit-stuffing run lengths
   localparam logic [2:0] HDLC_STUFF_RUN = 3'h5;
   localparam logic [2:0] HDLC_FLAG_RUN = 3'h6;

   typedef enum logic [1:0] {
      MSP_MODE_ASYNC = 2'b00,
      MSP_MODE_CLK_INT = 2'b01,
      MSP_MODE_CLK_EXT = 2'b10,
      MSP_MODE_HDLC = 2'b11
   } msp_mode_t;

   // Control register layout, bit 7 down to bit 0
   typedef struct packed {
      logic rx_en;
      logic alt_pins;
      msp_mode_t mode;
      logic ext_clk;
      logic over8;
      logic seven_bits;
      logic rx_addr_en;
   } msp_ctrl_t;

   // Status register layout, bit 7 down to bit 0
   typedef struct packed {
      logic rx_full;
      logic rx_addr;
      logic overrun;
      logic framing;
      logic tx_hold_full;
      logic tx_busy;
      logic flag_seen;
      logic rx_busy;
   } msp_status_t;
endpackage

// ==== rtl/msp_rate_divider.sv ====
// Bit-rate divider: one-cycle enable every div_m1+1 clocks.
// Assumes div_m1 is held steady by the register file.
`timescale 1ns/1ps
`default_nettype none
module msp_rate_divider #(
   parameter int W = 8
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Divide value minus one
   input wire logic [W-1:0] div_m1,
   // Rate enable
   output logic tick
);
   logic [W-1:0] cnt;

   // Free-running count, divides by 1 to 2**W
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt <= '0;
      end else if (cnt >= div_m1) begin
         cnt <= '0;
      end else begin
         cnt <= cnt + 1'b1;
      end
   end

   assign tick = (cnt >= div_m1);

   property p_div_period;
      @(posedge aclk) disable iff (!aresetn)
      (tick && div_m1 == W'(3)) |=> (!tick)[*3] ##1 tick;
   endproperty
   a_div_period: assert property (p_div_period)
      else $error("divider period wrong");
endmodule
`default_nettype wire

// ==== rtl/msp_serial_port.sv ====
// One serial port: async, clocked and bit-stuffed framing, AXI4-Lite regs.
// Assumes pins are synchronous to aclk; partner keeps framing and rates.
//
// Local design decisions: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Data register write starts transmission
// - Least significant bit always sent first
// - Seven or eight data bits selectable
// - Alternate address appends address bit in async mode
// - Register choice sets address bit value
// - No parity; address bit emulates extras
// - Received bits assembled LSB first
// - Async oversampling at 8 or 16
// - Clocked internal bit is two ticks
// - Dedicated divider, 1 to 256
// - All async; first four also clocked
// - Clocked mode clock pin bidirectional
// - First two ports have alternate pins
// - Last two ports do bit-stuffed framing
// - Optional external transmit and receive clocks
// - First port feeds boot loader
// - Async above 500 kbps, clocked faster
// - Control sets parameters; status reports state
// - Six registers per port
// - Data read returns receive buffer
module msp_serial_port #(
   parameter bit HAS_CLOCKED = 1'b1,
   parameter bit HAS_ALT_PINS = 1'b1,
   parameter bit HAS_HDLC = 1'b0,
   parameter bit IS_BOOT_PORT = 1'b1,
   parameter int ADDR_W = 5
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write channels
   input wire logic awvalid,
   output logic awready,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // AXI4-Lite read channels
   input wire logic arvalid,
   output logic arready,
   input wire logic [ADDR_W-1:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // Serial data pins
   output logic ser_out,
   input wire logic ser_in,
   output logic alt_ser_out,
   input wire logic alt_ser_in,
   // Clocked-mode clock pin
   input wire logic bit_clock_in,
   output logic bit_clock_out,
   output logic bit_clock_oe_n,
   // External framing clocks
   input wire logic ext_tx_clock,
   input wire logic ext_rx_clock,
   // Received bytes for a boot loader
   output logic boot_rx_valid,
   output logic [7:0] boot_rx_data
);
   typedef enum logic [2:0] {
      TX_IDLE = 3'b000, TX_START = 3'b001, TX_DATA = 3'b010,
      TX_ADDR = 3'b011, TX_STOP = 3'b100
   } msp_tx_state_t;
   typedef enum logic [1:0] {
      RX_IDLE = 2'b00, RX_START = 2'b01, RX_BITS = 2'b10, RX_STOP = 2'b11
   } msp_rx_state_t;

   msp_pkg::msp_ctrl_t ctrl;
   msp_pkg::msp_status_t status;
   msp_pkg::msp_mode_t mode;
   msp_tx_state_t tx_state;
   msp_rx_state_t rx_state;
   logic [7:0] div_m1, tx_hold, tx_shift, rx_data, rd_byte;
   logic [8:0] rx_sh, rx_word;
   logic [4:0] os_max, half_m1, tx_os, rx_os;
   logic [3:0] data_len, rx_len, tx_cnt, rx_cnt;
   logic [2:0] tx_ones, rx_ones, aw_idx;
   logic is_async, is_hdlc, div_tick, wr_fire, wr_en, rd_fire, rd_ok;
   logic aw_held, w_held, aw_ok, w_lane;
   logic [7:0] w_byte;
   logic tx_hold_full, tx_hold_addr, tx_hold_val, tx_hold_raw;
   logic tx_addr_en, tx_addr_val, tx_raw, tx_line, tx_take, tx_tick;
   logic stuff, clk_int, clk_run, tx_src, rx_src, tx_src_q, rx_src_q;
   logic rx_line, rx_samp, rx_store, rx_ferr, flag_ev, rx_addr_got;
   logic rd_data_ev, rd_stat_ev;
   logic rx_full, overrun, framing, flag_seen;

   // Effective mode; unsupported modes fall back to async
   always_comb begin
      mode = ctrl.mode;
      if (!HAS_CLOCKED && (mode == msp_pkg::MSP_MODE_CLK_INT ||
                           mode == msp_pkg::MSP_MODE_CLK_EXT)) begin
         mode = msp_pkg::MSP_MODE_ASYNC;
      end
      if (!HAS_HDLC && mode == msp_pkg::MSP_MODE_HDLC) begin
         mode = msp_pkg::MSP_MODE_ASYNC;
      end
   end

   // Frame geometry from control
   assign is_async = (mode == msp_pkg::MSP_MODE_ASYNC);
   assign is_hdlc = (mode == msp_pkg::MSP_MODE_HDLC);
   assign data_len = ctrl.seven_bits ? msp_pkg::LEN_SEVEN
                                     : msp_pkg::LEN_EIGHT;
   assign os_max = (ctrl.over8 ? msp_pkg::OS_X8 : msp_pkg::OS_X16)
                   - 5'h01;
   assign half_m1 = ((os_max + 5'h01) >> 1) - 5'h01;
   assign rx_len = data_len + {3'h0, is_async & ctrl.rx_addr_en};

   // Dedicated bit-rate divider
   msp_rate_divider #(.W(8)) u_div (
      .aclk(aclk),
      .aresetn(aresetn),
      .div_m1(div_m1),
      .tick(div_tick)
   );

   // Write address and data taken in either order
   assign awready = !aw_held && !bvalid;
   assign wready = !w_held && !bvalid;
   assign wr_fire = aw_held && w_held && !bvalid;
   assign wr_en = wr_fire && aw_ok && w_lane;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_idx <= 3'h0;
         aw_ok <= 1'b0;
         w_byte <= 8'h00;
         w_lane <= 1'b0;
         bvalid <= 1'b0;
         bresp <= msp_pkg::RESP_OKAY;
      end else begin
         if (awvalid && awready) begin
            aw_held <= 1'b1;
            aw_idx <= awaddr[4:2];
            aw_ok <= awaddr[1:0] == 2'h0 && awaddr[4:2] <= msp_pkg::IDX_EXT
                     && awaddr[4:2] != msp_pkg::IDX_STATUS;
         end
         if (wvalid && wready) begin
            w_held <= 1'b1;
            w_byte <= wdata[7:0];
            w_lane <= wstrb[0];
         end
         if (wr_fire) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            bvalid <= 1'b1;
            bresp <= aw_ok ? msp_pkg::RESP_OKAY : msp_pkg::RESP_SLVERR;
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // Read decode and read side effects
   assign arready = !rvalid;
   assign rd_fire = arvalid && arready;
   assign rd_ok = araddr[1:0] == 2'h0 && araddr[4:2] <= msp_pkg::IDX_EXT;
   assign rd_data_ev = rd_fire && rd_ok && araddr[4:2] == msp_pkg::IDX_DATA;
   assign rd_stat_ev = rd_fire && rd_ok
                       && araddr[4:2] == msp_pkg::IDX_STATUS;
   always_comb begin
      unique case (araddr[4:2])
         msp_pkg::IDX_DATA: rd_byte = rx_data;
         msp_pkg::IDX_STATUS: rd_byte = status;
         msp_pkg::IDX_CTRL: rd_byte = ctrl;
         msp_pkg::IDX_EXT: rd_byte = div_m1;
         default: rd_byte = 8'h00;
      endcase
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= msp_pkg::RESP_OKAY;
      end else if (rd_fire) begin
         rvalid <= 1'b1;
         rdata <= {24'h00_0000, rd_ok ? rd_byte : 8'h00};
         rresp <= rd_ok ? msp_pkg::RESP_OKAY : msp_pkg::RESP_SLVERR;
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
      end
   end

   // Control and divider registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl <= msp_pkg::CTRL_RESET;
         div_m1 <= msp_pkg::EXT_RESET;
      end else if (wr_en && aw_idx == msp_pkg::IDX_CTRL) begin
         ctrl <= w_byte;
      end else if (wr_en && aw_idx == msp_pkg::IDX_EXT) begin
         div_m1 <= w_byte;
      end
   end

   // Transmit holding register; data, address and long-stop writes
   assign tx_take = tx_state == TX_IDLE && tx_hold_full;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_hold_full <= 1'b0;
         tx_hold <= 8'h00;
         tx_hold_addr <= 1'b0;
         tx_hold_val <= 1'b0;
         tx_hold_raw <= 1'b0;
      end else if (wr_en && aw_idx <= msp_pkg::IDX_LSTOP) begin
         tx_hold_full <= 1'b1;
         tx_hold <= w_byte;
         tx_hold_addr <= aw_idx != msp_pkg::IDX_DATA;
         tx_hold_val <= aw_idx == msp_pkg::IDX_LSTOP;
         tx_hold_raw <= aw_idx == msp_pkg::IDX_ADDR;
      end else if (tx_take) begin
         tx_hold_full <= 1'b0;
      end
   end

   // Internal bit clock, two divider ticks per bit
   assign clk_run = (mode == msp_pkg::MSP_MODE_CLK_INT ||
                     (is_hdlc && !ctrl.ext_clk)) &&
                    (tx_state != TX_IDLE || tx_hold_full || ctrl.rx_en);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clk_int <= 1'b1;
      end else if (!clk_run) begin
         clk_int <= 1'b1;
      end else if (div_tick) begin
         clk_int <= !clk_int;
      end
   end
   assign bit_clock_out = clk_int;
   assign bit_clock_oe_n = mode != msp_pkg::MSP_MODE_CLK_INT;

   // Clock sources and their edges
   assign tx_src = (mode == msp_pkg::MSP_MODE_CLK_EXT) ? bit_clock_in :
                   (is_hdlc && ctrl.ext_clk) ? ext_tx_clock : clk_int;
   assign rx_src = (mode == msp_pkg::MSP_MODE_CLK_EXT) ? bit_clock_in :
                   (is_hdlc && ctrl.ext_clk) ? ext_rx_clock : clk_int;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_src_q <= 1'b1;
         rx_src_q <= 1'b1;
      end else begin
         tx_src_q <= tx_src;
         rx_src_q <= rx_src;
      end
   end
   assign tx_tick = is_async ? (div_tick && tx_os == os_max)
                             : (tx_src_q && !tx_src);
   assign rx_samp = is_async ? (div_tick && rx_os == os_max)
                             : (!rx_src_q && rx_src && ctrl.rx_en);

   // Transmit engine
   assign stuff = is_hdlc && !tx_raw && tx_ones == msp_pkg::HDLC_STUFF_RUN;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_state <= TX_IDLE;
         tx_line <= 1'b1;
         tx_shift <= 8'h00;
         tx_cnt <= 4'h0;
         tx_os <= 5'h00;
         tx_ones <= 3'h0;
         tx_addr_en <= 1'b0;
         tx_addr_val <= 1'b0;
         tx_raw <= 1'b0;
      end else begin
         if (tx_state == TX_IDLE) begin
            tx_os <= 5'h00;
         end else if (div_tick) begin
            tx_os <= (tx_os == os_max) ? 5'h00 : tx_os + 5'h01;
         end
         unique case (tx_state)
            TX_IDLE: if (tx_take) begin
               tx_state <= TX_START;
               tx_shift <= tx_hold;
               tx_addr_en <= tx_hold_addr;
               tx_addr_val <= tx_hold_val;
               tx_raw <= tx_hold_raw;
               tx_cnt <= 4'h0;
               tx_ones <= 3'h0;
               if (is_async) tx_line <= 1'b0;
            end
            TX_START: if (tx_tick) begin
               tx_line <= tx_shift[0];
               tx_shift <= tx_shift >> 1;
               tx_ones <= tx_shift[0] ? 3'h1 : 3'h0;
               tx_state <= TX_DATA;
            end
            TX_DATA: if (tx_tick) begin
               if (stuff) begin
                  tx_line <= 1'b0;
                  tx_ones <= 3'h0;
               end else if (tx_cnt == data_len - 4'h1) begin
                  if (is_async && tx_addr_en) begin
                     tx_line <= tx_addr_val;
                     tx_state <= TX_ADDR;
                  end else begin
                     tx_line <= 1'b1;
                     tx_state <= is_async ? TX_STOP : TX_IDLE;
                  end
               end else begin
                  tx_line <= tx_shift[0];
                  tx_shift <= tx_shift >> 1;
                  tx_ones <= tx_shift[0] ? (tx_ones == 3'h7 ? 3'h7
                                           : tx_ones + 3'h1) : 3'h0;
                  tx_cnt <= tx_cnt + 4'h1;
               end
            end
            TX_ADDR: if (tx_tick) begin
               tx_line <= 1'b1;
               tx_state <= TX_STOP;
            end
            TX_STOP: if (tx_tick) tx_state <= TX_IDLE;
            default: tx_state <= TX_IDLE;
         endcase
      end
   end

   // Pin routing to the main or alternate pair
   assign ser_out = (HAS_ALT_PINS && ctrl.alt_pins) ? 1'b1 : tx_line;
   assign alt_ser_out = (HAS_ALT_PINS && ctrl.alt_pins) ? tx_line : 1'b1;
   assign rx_line = (HAS_ALT_PINS && ctrl.alt_pins) ? alt_ser_in
                                                    : ser_in;

   // Receive engine
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_state <= RX_IDLE;
         rx_sh <= 9'h000;
         rx_cnt <= 4'h0;
         rx_os <= 5'h00;
         rx_ones <= 3'h0;
         rx_store <= 1'b0;
         rx_ferr <= 1'b0;
         flag_ev <= 1'b0;
      end else begin
         rx_store <= 1'b0;
         rx_ferr <= 1'b0;
         flag_ev <= 1'b0;
         if (div_tick) begin
            rx_os <= (rx_os == os_max) ? 5'h00 : rx_os + 5'h01;
         end
         unique case (rx_state)
            RX_IDLE: begin
               rx_cnt <= 4'h0;
               if (!is_async && ctrl.rx_en) begin
                  rx_state <= RX_BITS;
               end else if (is_async && ctrl.rx_en && div_tick
                            && !rx_line) begin
                  rx_state <= RX_START;
                  rx_os <= 5'h00;
               end
            end
            RX_START: if (div_tick && rx_os == half_m1) begin
               rx_os <= 5'h00;
               rx_state <= rx_line ? RX_IDLE : RX_BITS;
            end
            RX_BITS: if (!ctrl.rx_en && !is_async) begin
               rx_state <= RX_IDLE;
            end else if (rx_samp) begin
               if (is_hdlc && !rx_line
                   && rx_ones == msp_pkg::HDLC_STUFF_RUN) begin
                  rx_ones <= 3'h0;
               end else if (is_hdlc && !rx_line
                            && rx_ones == msp_pkg::HDLC_FLAG_RUN) begin
                  rx_ones <= 3'h0;
                  rx_cnt <= 4'h0;
                  flag_ev <= 1'b1;
               end else begin
                  rx_ones <= rx_line ? (rx_ones == 3'h7 ? 3'h7
                                       : rx_ones + 3'h1) : 3'h0;
                  rx_sh <= {rx_line, rx_sh[8:1]};
                  if (rx_cnt == rx_len - 4'h1) begin
                     rx_cnt <= 4'h0;
                     if (is_async) rx_state <= RX_STOP;
                     else rx_store <= 1'b1;
                  end else begin
                     rx_cnt <= rx_cnt + 4'h1;
                  end
               end
            end
            RX_STOP: if (rx_samp) begin
               rx_state <= RX_IDLE;
               rx_store <= 1'b1;
               rx_ferr <= !rx_line;
            end
         endcase
      end
   end

   // Align the assembled character into the receive buffer
   assign rx_word = rx_sh >> (msp_pkg::RX_SH_W - rx_len);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_data <= 8'h00;
         rx_addr_got <= 1'b0;
         boot_rx_valid <= 1'b0;
      end else begin
         boot_rx_valid <= rx_store && IS_BOOT_PORT;
         if (rx_store) begin
            rx_data <= ctrl.seven_bits ? {1'b0, rx_word[6:0]}
                                       : rx_word[7:0];
            rx_addr_got <= is_async && ctrl.rx_addr_en &&
                           (ctrl.seven_bits ? rx_word[7] : rx_word[8]);
         end
      end
   end
   assign boot_rx_data = rx_data;

   // Sticky status flags; a set beats a same-cycle clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_full <= 1'b0;
         overrun <= 1'b0;
         framing <= 1'b0;
         flag_seen <= 1'b0;
      end else begin
         rx_full <= rx_store || (rx_full && !rd_data_ev);
         overrun <= (rx_store && rx_full && !rd_data_ev)
                    || (overrun && !rd_stat_ev);
         framing <= rx_ferr || (framing && !rd_stat_ev);
         flag_seen <= flag_ev || (flag_seen && !rd_stat_ev);
      end
   end
   assign status = '{rx_full, rx_addr_got, overrun, framing, tx_hold_full,
                     tx_state != TX_IDLE, flag_seen, rx_state != RX_IDLE};

   property p_write_starts;
      @(posedge aclk) disable iff (!aresetn)
      (wr_en && aw_idx == msp_pkg::IDX_DATA && tx_state == TX_IDLE)
      |=> ##1 tx_state == TX_START;
   endproperty
   a_write_starts: assert property (p_write_starts)
      else $error("data write did not start transmit");

   property p_start_low;
      @(posedge aclk) disable iff (!aresetn)
      (tx_state == TX_START && is_async) |-> !tx_line;
   endproperty
   a_start_low: assert property (p_start_low)
      else $error("start bit not low");

   property p_lsb_first;
      @(posedge aclk) disable iff (!aresetn)
      (tx_state == TX_START && tx_tick) |=> tx_line == $past(tx_shift[0]);
   endproperty
   a_lsb_first: assert property (p_lsb_first)
      else $error("first data bit not bit 0");

   property p_addr_value;
      @(posedge aclk) disable iff (!aresetn)
      tx_state == TX_ADDR |-> tx_line == tx_addr_val;
   endproperty
   a_addr_value: assert property (p_addr_value)
      else $error("address bit value wrong");

   property p_stop_high;
      @(posedge aclk) disable iff (!aresetn)
      tx_state == TX_STOP |-> tx_line;
   endproperty
   a_stop_high: assert property (p_stop_high)
      else $error("stop bit not high");

   property p_os_spacing;
      @(posedge aclk) disable iff (!aresetn)
      (tx_tick && is_async && tx_state != TX_STOP) |=> (!tx_tick)[*7];
   endproperty
   a_os_spacing: assert property (p_os_spacing)
      else $error("async bit shorter than eight ticks");

   property p_rx_full;
      @(posedge aclk) disable iff (!aresetn)
      rx_store |=> rx_full && boot_rx_valid == IS_BOOT_PORT
                   && rx_data[6:0] == $past(rx_word[6:0]);
   endproperty
   a_rx_full: assert property (p_rx_full)
      else $error("received byte not flagged");

   property p_data_read;
      @(posedge aclk) disable iff (!aresetn)
      rd_data_ev |=> rvalid && rdata[7:0] == $past(rx_data);
   endproperty
   a_data_read: assert property (p_data_read)
      else $error("data read mismatch");

   property p_clk_drive;
      @(posedge aclk) disable iff (!aresetn)
      (mode == msp_pkg::MSP_MODE_CLK_EXT) |-> bit_clock_oe_n;
   endproperty
   a_clk_drive: assert property (p_clk_drive)
      else $error("clock pin driven in external mode");
endmodule
`default_nettype wire
